// File: common/cac_pkg.sv
// Purpose: Shared constants for the counter array control and status block.
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register.
// Notes:   Offsets, field positions and reset values live only here.
package cac_pkg;

  // Register byte offsets (low address byte only; hsel qualifies the rest)
  localparam logic [7:0] CTRL_OFS = 8'h00;  // Run bit and sticky event flags
  localparam logic [7:0] MASK_OFS = 8'h04;  // Interrupt enables, same layout
  localparam logic [7:0] EVT_OFS  = 8'h08;  // Interrupt status, write one to clear

  // Field positions inside each 8-bit register
  localparam int OVF_BIT = 7;  // Counter overflow flag
  localparam int RUN_BIT = 6;  // Counter run control
  localparam int MOD_MSB = 5;  // Highest module flag
  localparam int MOD_LSB = 0;  // Lowest module flag
  localparam int NUM_MOD = 6;  // Capture/compare modules
  localparam int REG_W   = 8;  // Register width

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;  // Stopped, no flags
  localparam logic [7:0] MASK_RST = 8'h00;  // All interrupts disabled
  localparam logic [7:0] EVT_RST  = 8'h00;  // No pending events

  // Bits that actually exist in the interrupt status and mask registers
  localparam logic [7:0] EVT_VALID = 8'hBF;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // Address match on the low byte, shared by read and write decode
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

endpackage

// File: rtl/cac_ahb_slave.sv
// Purpose: AHB-Lite slave front end, turns bus transfers into register strobes.
// Assumes: Single word transfers; slave never inserts wait states.
// Notes:   Write strobe fires at the end of the data phase with hwdata.
`timescale 1ns/100ps
module cac_ahb_slave (
  input  wire logic        sys_clk_i,   // System clock
  input  wire logic        rst_i,       // Asynchronous reset, active high
  input  wire logic        hsel_i,      // Slave select
  input  wire logic [31:0] haddr_i,     // Byte address
  input  wire logic [1:0]  htrans_i,    // Transfer type
  input  wire logic        hwrite_i,    // Write when high
  input  wire logic [2:0]  hsize_i,     // Transfer size
  input  wire logic        hready_i,    // Bus ready
  input  wire logic [31:0] hwdata_i,    // Write data
  output logic             hreadyout_o, // Always ready after reset
  output logic             rd_en_o,     // Address phase of a read, combinational
  output logic [7:0]       rd_addr_o,   // Read offset, combinational
  output logic             wr_en_o,     // One-cycle write strobe
  output logic [7:0]       wr_addr_o,   // Write offset
  output logic [7:0]       wr_data_o    // Write data, low byte
);

  logic       valid_xfer;    // Accepted address phase
  logic       wr_pend_reg;   // Write data phase in progress
  logic [7:0] wr_addr_reg;   // Offset latched at the address phase

  // A transfer is taken only when the previous one has finished
  assign valid_xfer = hsel_i && hready_i &&
                      ((htrans_i == cac_pkg::HTRANS_NONSEQ) ||
                       (htrans_i == cac_pkg::HTRANS_SEQ));

  // Reads are served from the address phase so data stands in the data phase
  assign rd_en_o   = valid_xfer && !hwrite_i;
  assign rd_addr_o = haddr_i[7:0];

  // Latch a word write; other sizes are ignored but still answered OKAY
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (hready_i) begin
      wr_pend_reg <= valid_xfer && hwrite_i && (hsize_i == cac_pkg::HSIZE_WORD);
      wr_addr_reg <= haddr_i[7:0];
    end
  end

  // No wait states: hreadyout stays high, held in a flop so reset is clean
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hreadyout_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
    end
  end

  // Data phase lasts exactly one cycle since the slave is always ready
  assign wr_en_o   = wr_pend_reg;
  assign wr_addr_o = wr_addr_reg;
  assign wr_data_o = hwdata_i[7:0];

endmodule // cac_ahb_slave

// File: rtl/cac_top.sv
// Purpose: Run control and sticky event flags of a counter array, with interrupts.
// Assumes: Counter wrap and module events arrive as one-cycle pulses on sys_clk_i.
// Notes:   The counter and module datapaths live outside; this block gates and flags.
//
// Functional notes
// RULE1: Control bit 6 runs or halts counter.
// RULE2: Module flags bits 5..1 set on event.
// RULE3: Enabled module flag raises shared module request.
// RULE4: Hardware never clears flags; software must.
// RULE5: Overflow flag has own request, software-cleared.
// RULE6: Counter wrap to zero sets bit 7.
// RULE7: Module zero flag sits in bit 0.
// RULE8: Writing zero clears flag; set wins.
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module cac_top (
  input  wire logic        sys_clk_i,       // System clock, 100 MHz
  input  wire logic        rst_i,           // Asynchronous reset, active high
  input  wire logic        hsel_i,          // AHB slave select
  input  wire logic [31:0] haddr_i,         // AHB address
  input  wire logic [1:0]  htrans_i,        // AHB transfer type
  input  wire logic        hwrite_i,        // AHB write
  input  wire logic [2:0]  hsize_i,         // AHB size
  input  wire logic        hready_i,        // AHB ready in
  input  wire logic [31:0] hwdata_i,        // AHB write data
  output logic [31:0]      hrdata_o,        // AHB read data
  output logic             hreadyout_o,     // AHB ready out
  output logic             hresp_o,         // AHB response, always OKAY
  input  wire logic        count_wrap_i,    // Counter passed 0xFFFF to 0x0000
  input  wire logic [5:0]  module_event_i,  // Match or capture per module
  output logic             counter_run_o,   // Counter enable
  output logic             ovf_req_o,       // Overflow service request
  output logic             module_req_o,    // Shared module service request
  output logic             irq_o            // Combined level interrupt
);

  // Bus strobes from the slave front end
  logic       rd_en;        // Read address phase
  logic [7:0] rd_addr;      // Read offset
  logic       wr_en;        // Write data phase end
  logic [7:0] wr_addr;      // Write offset
  logic [7:0] wr_data;      // Write data byte

  // Register state
  logic                     run_reg;       // Counter run control
  logic                     ovf_reg;       // Counter overflow flag
  logic [5:0]               mod_reg;       // Module event flags, bit n is module n
  logic [7:0]               mask_reg;      // Interrupt enables
  logic [7:0]               evt_reg;       // Interrupt status, sticky
  logic                     ovf_next;      // Next overflow flag
  logic [5:0]               mod_next;      // Next module flags
  logic [7:0]               evt_next;      // Next interrupt status
  logic [7:0]               ctrl_view;     // Control register as read
  logic [7:0]               raise;         // Hardware set events in status layout
  logic                     wr_ctrl;       // Write to control register
  logic                     wr_mask;       // Write to mask register
  logic                     wr_evt;        // Write to status register

  // Bus front end; it keeps the protocol, this module keeps the registers
  cac_ahb_slave u_bus (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hsize_i     (hsize_i),
    .hready_i    (hready_i),
    .hwdata_i    (hwdata_i),
    .hreadyout_o (hreadyout_o),
    .rd_en_o     (rd_en),
    .rd_addr_o   (rd_addr),
    .wr_en_o     (wr_en),
    .wr_addr_o   (wr_addr),
    .wr_data_o   (wr_data)
  );

  // Write decode, shared match function keeps read and write maps identical
  assign wr_ctrl = wr_en && cac_pkg::reg_hit(wr_addr, cac_pkg::CTRL_OFS);
  assign wr_mask = wr_en && cac_pkg::reg_hit(wr_addr, cac_pkg::MASK_OFS);
  assign wr_evt  = wr_en && cac_pkg::reg_hit(wr_addr, cac_pkg::EVT_OFS);

  // Control register as software sees it
  always_comb begin
    ctrl_view                                    = cac_pkg::CTRL_RST;
    ctrl_view[cac_pkg::OVF_BIT]                  = ovf_reg;
    ctrl_view[cac_pkg::RUN_BIT]                  = run_reg;
    ctrl_view[cac_pkg::MOD_MSB:cac_pkg::MOD_LSB] = mod_reg;
  end

  // Hardware events mapped onto the control layout
  always_comb begin
    raise                                    = 8'h00;
    raise[cac_pkg::OVF_BIT]                  = count_wrap_i;    // [RULE6]
    raise[cac_pkg::MOD_MSB:cac_pkg::MOD_LSB] = module_event_i;  // [RULE2] [RULE7]
  end

  // Flag next state: a written zero clears, a written one keeps, events set.
  // Nothing else clears a flag, so a taken interrupt leaves it for software.
  always_comb begin
    ovf_next = ovf_reg;
    mod_next = mod_reg;
    if (wr_ctrl) begin
      // Write-zero clear only; a one never sets a flag from software
      ovf_next = ovf_reg & wr_data[cac_pkg::OVF_BIT];                    // [RULE8] [RULE5]
      mod_next = mod_reg & wr_data[cac_pkg::MOD_MSB:cac_pkg::MOD_LSB];   // [RULE8] [RULE4]
    end
    // Set is applied last so an event in the clearing cycle is not lost
    ovf_next = ovf_next | raise[cac_pkg::OVF_BIT];                     // [RULE6] [RULE8]
    mod_next = mod_next | raise[cac_pkg::MOD_MSB:cac_pkg::MOD_LSB];    // [RULE2] [RULE7] [RULE8]
  end

  // Run control is a plain read/write bit
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_reg <= cac_pkg::CTRL_RST[cac_pkg::RUN_BIT];
    end else if (wr_ctrl) begin
      run_reg <= wr_data[cac_pkg::RUN_BIT];  // [RULE1]
    end
  end

  // Sticky flags; only a software write of zero removes them
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf_reg <= cac_pkg::CTRL_RST[cac_pkg::OVF_BIT];
      mod_reg <= cac_pkg::CTRL_RST[cac_pkg::MOD_MSB:cac_pkg::MOD_LSB];
    end else begin
      ovf_reg <= ovf_next;  // [RULE4] [RULE5]
      mod_reg <= mod_next;  // [RULE4]
    end
  end

  // Interrupt enables; bit 6 has no event behind it and stays zero
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_reg <= cac_pkg::MASK_RST;
    end else if (wr_mask) begin
      mask_reg <= wr_data & cac_pkg::EVT_VALID;
    end
  end

  // Interrupt status: set by each event, cleared by writing one.
  // Set wins over the clear in the same cycle.
  always_comb begin
    evt_next = evt_reg;
    if (wr_evt) begin
      evt_next = evt_reg & ~wr_data;
    end
    evt_next = (evt_next | raise) & cac_pkg::EVT_VALID;
  end

  // Status register flop
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      evt_reg <= cac_pkg::EVT_RST;
    end else begin
      evt_reg <= evt_next;
    end
  end

  // Service requests follow the sticky flags, so a request stays up until
  // software clears the flag; registered for clean outputs, one cycle late.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf_req_o    <= 1'b0;
      module_req_o <= 1'b0;
      irq_o        <= 1'b0;
    end else begin
      ovf_req_o    <= ovf_reg & mask_reg[cac_pkg::OVF_BIT];  // [RULE5]
      module_req_o <= |(mod_reg &
                        mask_reg[cac_pkg::MOD_MSB:cac_pkg::MOD_LSB]);  // [RULE3]
      irq_o        <= |(evt_reg & mask_reg);
    end
  end

  // Counter enable drives the external counter from the run bit through one flop, a cycle late
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      counter_run_o <= 1'b0;
    end else begin
      counter_run_o <= run_reg;  // [RULE1]
    end
  end

  // Read data captured in the address phase; unmapped offsets read zero.
  // A read right after a write to the same register returns the old value.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (rd_en) begin
      if (cac_pkg::reg_hit(rd_addr, cac_pkg::CTRL_OFS)) begin
        hrdata_o <= {24'h00_0000, ctrl_view};
      end else if (cac_pkg::reg_hit(rd_addr, cac_pkg::MASK_OFS)) begin
        hrdata_o <= {24'h00_0000, mask_reg};
      end else if (cac_pkg::reg_hit(rd_addr, cac_pkg::EVT_OFS)) begin
        hrdata_o <= {24'h00_0000, evt_reg};
      end else begin
        hrdata_o <= 32'h0000_0000;
      end
    end
  end

  // Every transfer completes OKAY
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hresp_o <= cac_pkg::HRESP_OKAY;
    end else begin
      hresp_o <= cac_pkg::HRESP_OKAY;
    end
  end

endmodule // cac_top

// File: tb/cac_top_props.sv
// Purpose: Port-level checks for the counter array control block.
// Assumes: Zero-wait bus; a taken write moves outputs two edges later.
// Notes:   Events move requests one edge later; flags only fall by software.
`timescale 1ns/100ps
module cac_top_props (
  input wire logic       sys_clk_i,
  input wire logic       rst_i,
  input wire logic       hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic       hwrite_i,
  input wire logic       hready_i,
  input wire logic       hreadyout_o,
  input wire logic       hresp_o,
  input wire logic       count_wrap_i,
  input wire logic [5:0] module_event_i,
  input wire logic       counter_run_o,
  input wire logic       ovf_req_o,
  input wire logic       module_req_o,
  input wire logic       irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic wr_take;  // Write address phase taken at this edge
  assign wr_take = hsel_i && hready_i && htrans_i[1] && hwrite_i;
  // Software reached a register: the address phase was taken three edges
  // back, the register moved at the next edge and the output one edge later.
  sequence s_sw_write;
    $past(wr_take, 3);
  endsequence
  // Hardware event sampled two edges back, at the edge that set the flag
  sequence s_hw_event;
    $past(count_wrap_i || (|module_event_i), 2);
  endsequence
  chk_run_by_write: assert property ($changed(counter_run_o) |-> s_sw_write)
    else $error("run output moved without a write");
  chk_ovf_sticky: assert property ($fell(ovf_req_o) |-> s_sw_write)
    else $error("overflow request fell without a write");
  chk_mod_sticky: assert property ($fell(module_req_o) |-> s_sw_write)
    else $error("module request fell without a write");
  chk_irq_sticky: assert property ($fell(irq_o) |-> s_sw_write)
    else $error("interrupt fell without a write");
  chk_ovf_cause: assert property ($rose(ovf_req_o) |-> $past(count_wrap_i, 2) or s_sw_write)
    else $error("overflow request rose without a wrap");
  chk_mod_cause: assert property ($rose(module_req_o) |-> s_hw_event or s_sw_write)
    else $error("module request rose without an event");
  chk_irq_cause: assert property ($rose(irq_o) |-> s_hw_event or s_sw_write)
    else $error("interrupt rose without an event");
  // Zero wait states and OKAY once out of reset
  chk_ready_always: assert property ($past(!rst_i) |-> hreadyout_o)
    else $error("slave inserted a wait state");
  chk_resp_okay: assert property (hresp_o == cac_pkg::HRESP_OKAY)
    else $error("slave answered other than OKAY");
endmodule  // cac_top_props

bind cac_top cac_top_props u_props (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .count_wrap_i(count_wrap_i), .module_event_i(module_event_i),
  .counter_run_o(counter_run_o), .ovf_req_o(ovf_req_o),
  .module_req_o(module_req_o), .irq_o(irq_o));

// File: tb/testbench.sv
// Purpose: Self-checking bench for the counter array control block.
// Assumes: Zero-wait AHB-Lite slave; events land in flag and status bits.
// Notes:   A byte model of control, mask and status predicts every result.
`timescale 1ns/100ps
module testbench;
  logic        sys_clk_i = 1'b0;   // 100 MHz clock
  logic        rst_i     = 1'b1;   // Held for 12 cycles
  logic        hsel_i    = 1'b0;
  logic [31:0] haddr_i   = 32'h0000_0000;
  logic [1:0]  htrans_i  = 2'h0;
  logic        hwrite_i  = 1'b0;
  logic [2:0]  hsize_i   = 3'h2;
  logic [31:0] hwdata_i  = 32'h0000_0000;
  logic        wrap      = 1'b0;   // Counter wrap pulse
  logic [5:0]  mod_ev    = 6'h00;  // Module event pulses
  logic [31:0] hrdata_o;
  logic        rdy, resp, run, ovf_req, mod_req, irq;
  logic [7:0]  ctrl_m = 8'h00, mask_m = 8'h00, evt_m = 8'h00;  // Model
  logic [7:0]  e, ad;
  int          failures = 0, n_compared = 0, seed = 94;
  always #5 sys_clk_i = ~sys_clk_i;
  cac_top dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(rdy),
    .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(rdy), .hresp_o(resp),
    .count_wrap_i(wrap), .module_event_i(mod_ev), .counter_run_o(run),
    .ovf_req_o(ovf_req), .module_req_o(mod_req), .irq_o(irq));
  task automatic test_done;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Model read value; unmapped offsets read zero
  function automatic logic [7:0] regv(input logic [7:0] a);
    case (a)
      cac_pkg::CTRL_OFS: regv = ctrl_m;
      cac_pkg::MASK_OFS: regv = mask_m;
      cac_pkg::EVT_OFS:  regv = evt_m;
      default:           regv = 8'h00;
    endcase
  endfunction
  // Wait for hready at a rising edge, bounded so a hang ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      test_done();
    end
  endtask
  // One transfer at the size on hsize_i; ev pulses events in the data phase to race a write
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      input logic [7:0] ev);
    logic [7:0] exp;
    exp = regv(a);
    haddr_i  <= {24'h00_0000, a};
    hwrite_i <= wr;
    htrans_i <= cac_pkg::HTRANS_NONSEQ;
    hsel_i   <= 1'b1;
    wait_rdy();
    htrans_i <= 2'h0;
    hwdata_i <= {24'h00_0000, d};
    wrap     <= ev[7];
    mod_ev   <= ev[5:0];
    wait_rdy();
    if (!wr) chk("rdata", hrdata_o, {24'h00_0000, exp});
    chk("resp", {31'h0, resp}, {31'h0, cac_pkg::HRESP_OKAY});
    wrap   <= 1'b0;
    mod_ev <= 6'h00;
    // A write of any size but a whole word is answered but refused
    wr = wr && (hsize_i == cac_pkg::HSIZE_WORD);
    if (wr && a == cac_pkg::CTRL_OFS) ctrl_m = (d & 8'h40) | (ctrl_m & d & 8'hBF);
    if (wr && a == cac_pkg::MASK_OFS) mask_m = d & cac_pkg::EVT_VALID;
    if (wr && a == cac_pkg::EVT_OFS) evt_m = evt_m & ~d;
    ctrl_m = ctrl_m | (ev & cac_pkg::EVT_VALID);  // Set wins over clear
    evt_m  = evt_m | (ev & cac_pkg::EVT_VALID);
  endtask
  // Outputs settle one edge after a register or flag update
  task automatic check_outs;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk("run", {31'h0, run}, {31'h0, ctrl_m[6]});
    chk("ovf_req", {31'h0, ovf_req}, {31'h0, ctrl_m[7] & mask_m[7]});
    chk("mod_req", {31'h0, mod_req}, {31'h0, |(ctrl_m[5:0] & mask_m[5:0])});
    chk("irq", {31'h0, irq}, {31'h0, |(evt_m & mask_m)});
    @(posedge sys_clk_i);
  endtask
  initial begin
    #100_000;
    failures++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    // Reset values of every word, the unmapped one included
    for (int i = 0; i < 4; i++) xfer(1'b0, 8'(i * 4), 8'h00, 8'h00);
    xfer(1'b1, cac_pkg::MASK_OFS, 8'hFF, 8'h00);
    // Each event source alone: set, hold, clear by software
    for (int b = 0; b < 8; b++) begin
      if (b == 6) continue;
      e = 8'h01 << b;
      xfer(1'b0, 8'h0C, 8'h00, e);
      check_outs();
      repeat (20) @(posedge sys_clk_i);
      check_outs();
      xfer(1'b0, cac_pkg::CTRL_OFS, 8'h00, 8'h00);
      xfer(1'b1, cac_pkg::CTRL_OFS, ~e, 8'h00);
      check_outs();
      xfer(1'b1, cac_pkg::EVT_OFS, e, 8'h00);
      check_outs();
    end
    // Clearing write and event at the same edge
    xfer(1'b1, cac_pkg::CTRL_OFS, 8'h00, 8'h84);
    check_outs();
    xfer(1'b1, cac_pkg::EVT_OFS, 8'hFF, 8'h21);
    check_outs();
    // Random mix of reads, writes and events
    for (int k = 0; k < 60; k++) begin
      ad = 8'(($random(seed) & 3) << 2);
      e  = (($random(seed) & 3) == 0) ? 8'($random(seed)) : 8'h00;
      hsize_i <= (($random(seed) & 7) == 0) ? 3'h0 : cac_pkg::HSIZE_WORD;
      xfer(1'($random(seed)), ad, 8'($random(seed)), e);
      check_outs();
    end
    // Reset in mid-run: every register and the run, request and interrupt outputs return to zero
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i  <= 1'b0;
    ctrl_m = 8'h00;
    mask_m = 8'h00;
    evt_m  = 8'h00;
    repeat (2) @(posedge sys_clk_i);
    for (int i = 0; i < 3; i++) xfer(1'b0, 8'(i * 4), 8'h00, 8'h00);
    check_outs();
    test_done();
  end
endmodule  // testbench
